// ==== design/ext_int_regs.svh ====
// Purpose: Constants of the external interrupt input detect block.
// Assumes: Included by its bare name from the package and the module.
// Notes: Widths, field positions, reset values and timing counts.
// Behaviour
// - Six request pins, level or edge sensed, priority 0 to 15 each.
// - Edge flag clears after it was read as 1, then written 0, or when its pin leaves edge mode.
// - Servicing these sources never changes the processor mask level.
// - Request pins 0 to 4 wake standby above mask, with 32-kHz clock.
// - Edges before standby indication or during frequency change may drop.
// - Encoded buses level sensed; bus b needs level mode and enable set.
// - With both buses active the higher level is taken.
// - Encoded level is 15 minus bus value; 1111 means no request.
// - Encoded level accepted after two identical consecutive samples.
// - In standby the encoded filter runs on the 32-kHz clock.
// - Encoded request above mask wakes standby with 32-kHz clock.
// - Sixteen level port pins, one priority per group of eight.
// - Port pins 0 and 1 wake standby above mask, with 32-kHz clock.
// - A source with priority 0 is masked and never forwarded.
// - Priorities, control and edge flags reset to zero; level-sensed request bits read the live pins.
`ifndef EXT_INT_REGS_SVH
`define EXT_INT_REGS_SVH
`define REQ_PINS 6
`define WAKE_REQ_PINS 5
`define PORT_PINS 16
`define BUS_W 4
`define SYNC_W 31
`define PRIO_W 16
`define SENSE_W 12
`define SENSE_EDGE_LSB 0
`define SENSE_POL_LSB 6
`define FLAG_W 8
`define CTRL_W 2
`define CTRL_LEVEL_MODE 0
`define CTRL_SECOND_BUS 1
`define PRIO_RESET 16'h0000
`define SENSE_RESET 12'h000
`define FLAG_RESET 8'h00
`define CTRL_RESET 2'h0
`define BUS_IDLE 4'hf
`define LEVEL_MAX 4'hf
`define PORT_LO_PRIO_LSB 12
`define PORT_HI_PRIO_LSB 8
`define FILTER_SAMPLES 2
// Encoded bus stages reset to the idle pattern so no request follows reset.
`define SYNC_RESET 31'h00003fc0
`endif

// ==== design/ext_int_pkg.sv ====
// Purpose: Types shared by the external interrupt input detect block.
// Assumes: Nothing beyond the constants header.
// Notes: Source codes are what the block reports with each request.
`default_nettype none
`include "ext_int_regs.svh"
package ext_int_pkg;
	typedef logic [3:0] level_t;
	typedef enum logic [3:0] {
		SRC_REQ0 = 4'h0,
		SRC_REQ1 = 4'h1,
		SRC_REQ2 = 4'h2,
		SRC_REQ3 = 4'h3,
		SRC_REQ4 = 4'h4,
		SRC_REQ5 = 4'h5,
		SRC_PORT_LO = 4'h6,
		SRC_PORT_HI = 4'h7,
		SRC_ENCODED = 4'h8,
		SRC_NONE = 4'hf
	} source_t;
endpackage
`default_nettype wire

// ==== design/external_interrupt_input_detect.sv ====
// Purpose: Detects and prioritises external interrupt requests from pins.
// Assumes: mclk is the peripheral clock; pins are asynchronous to it.
// Notes: The mask level is only read here; nothing in this block drives it.
`timescale 1ns/100ps
`default_nettype none
`include "ext_int_regs.svh"
module external_interrupt_input_detect (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// External pins
	input wire logic [`REQ_PINS-1:0] reqPins,
	input wire logic [`BUS_W-1:0] encodedLevelBusA,
	input wire logic [`BUS_W-1:0] encodedLevelBusB,
	input wire logic [`PORT_PINS-1:0] portIntPins,
	input wire logic rtcClk,
	// Priority register writes
	input wire logic prioCWe,
	input wire logic [`PRIO_W-1:0] prioCWdata,
	input wire logic prioDWe,
	input wire logic [`PRIO_W-1:0] prioDWdata,
	// Sense control and level mode control writes
	input wire logic senseWe,
	input wire logic [`SENSE_W-1:0] senseWdata,
	input wire logic ctrlWe,
	input wire logic [`CTRL_W-1:0] ctrlWdata,
	// Request flag register access
	input wire logic flagRd,
	input wire logic flagWe,
	input wire logic [`FLAG_W-1:0] flagWdata,
	// Processor state
	input wire logic [3:0] cpuMaskLevel,
	input wire logic standbyIndicator,
	input wire logic sleepPending,
	input wire logic freqChangeCount,
	input wire logic rtcRunning,
	// Register readback
	output logic [`PRIO_W-1:0] priorityRegC,
	output logic [`PRIO_W-1:0] priorityRegD,
	output logic [`SENSE_W-1:0] senseControlReg,
	output logic [`CTRL_W-1:0] ctrlReg,
	output logic [`FLAG_W-1:0] reqFlagReg,
	// Request toward the processor
	output logic irqValid,
	output logic [3:0] irqLevel,
	output logic [3:0] irqSource,
	output logic wakeup
);
	logic [`SYNC_W-1:0] syncA_q;
	logic [`SYNC_W-1:0] syncB_q;
	logic [`SYNC_W-1:0] syncA_d;
	logic [`SYNC_W-1:0] syncB_d;
	logic [`REQ_PINS-1:0] reqPrev_q;
	logic [`REQ_PINS-1:0] reqPrev_d;
	logic rtcPrev_q;
	logic rtcPrev_d;
	logic [`REQ_PINS-1:0] reqS;
	logic [`BUS_W-1:0] busAS;
	logic [`BUS_W-1:0] busBS;
	logic [`PORT_PINS-1:0] portS;
	logic rtcS;

	// Only the second stage is read by logic.
	always_comb begin
		syncA_d = {rtcClk, portIntPins, encodedLevelBusB,
			encodedLevelBusA, reqPins};
		syncB_d = syncA_q;
	end
	assign reqS = syncB_q[5:0];
	assign busAS = syncB_q[9:6];
	assign busBS = syncB_q[13:10];
	assign portS = syncB_q[29:14];
	assign rtcS = syncB_q[30];

	always_ff @(posedge mclk) begin
		if (reset) begin
			syncA_q <= `SYNC_RESET;
			syncB_q <= `SYNC_RESET;
		end else begin
			syncA_q <= syncA_d;
			syncB_q <= syncB_d;
		end
	end

	// Software visible registers.
	logic [`PRIO_W-1:0] prioC_q, prioC_d;
	logic [`PRIO_W-1:0] prioD_q, prioD_d;
	logic [`SENSE_W-1:0] sense_q, sense_d;
	logic [`CTRL_W-1:0] ctrl_q, ctrl_d;
	logic [`REQ_PINS-1:0] edgeFlag_q, edgeFlag_d;
	logic [`REQ_PINS-1:0] armed_q, armed_d;
	logic [`REQ_PINS-1:0] edgeMode;
	logic [`REQ_PINS-1:0] polarity;
	logic [`REQ_PINS-1:0] levelActive;
	logic [`REQ_PINS-1:0] edgeSeen;
	logic [`REQ_PINS-1:0] reqActive;
	logic edgeBlind;

	assign edgeMode = sense_q[`SENSE_EDGE_LSB +: `REQ_PINS];
	assign polarity = sense_q[`SENSE_POL_LSB +: `REQ_PINS];
	// While the sleep entry or a clock change is under way the edge
	// detector is blind; an edge re-applied once standby shows is taken.
	assign edgeBlind = (sleepPending & ~standbyIndicator) |
		freqChangeCount;

	genvar i;
	generate
		for (i = 0; i < `REQ_PINS; i++) begin : g_req
			// A pulse seen at one sampling edge passes both synchroniser
			// stages and the compare stage, so one cycle is the minimum width.
			assign edgeSeen[i] = ~edgeBlind & (polarity[i] ?
				(reqS[i] & ~reqPrev_q[i]) :
				(~reqS[i] & reqPrev_q[i]));
			assign levelActive[i] = polarity[i] ? reqS[i] : ~reqS[i];
			assign reqActive[i] = edgeMode[i] ? edgeFlag_q[i] :
				levelActive[i];
		end
	endgenerate

	always_comb begin
		prioC_d = prioC_q;
		prioD_d = prioD_q;
		sense_d = sense_q;
		ctrl_d = ctrl_q;
		armed_d = armed_q;
		edgeFlag_d = edgeFlag_q;
		reqPrev_d = reqS;
		if (prioCWe) begin
			prioC_d = prioCWdata;
		end
		if (prioDWe) begin
			prioD_d = prioDWdata;
		end
		// Rewriting sense control flushes only the flags of pins put in level mode;
		// software must clear the false ones itself before unmasking.
		if (senseWe) begin
			sense_d = senseWdata;
		end
		if (ctrlWe) begin
			ctrl_d = ctrlWdata;
		end
		// A read arms each flag seen as 1; a later write of 0 clears it.
		if (flagRd) begin
			armed_d = armed_q | edgeFlag_q;
		end
		if (flagWe) begin
			edgeFlag_d = edgeFlag_q &
				(flagWdata[`REQ_PINS-1:0] | ~armed_q);
			armed_d = {`REQ_PINS{1'b0}};
		end
		// A new edge in the clearing cycle wins over the clear.
		edgeFlag_d = (edgeFlag_d | (edgeSeen & edgeMode)) &
			edgeMode;
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			prioC_q <= `PRIO_RESET;
			prioD_q <= `PRIO_RESET;
			sense_q <= `SENSE_RESET;
			ctrl_q <= `CTRL_RESET;
			edgeFlag_q <= {`REQ_PINS{1'b0}};
			armed_q <= {`REQ_PINS{1'b0}};
			reqPrev_q <= {`REQ_PINS{1'b0}};
		end else begin
			prioC_q <= prioC_d;
			prioD_q <= prioD_d;
			sense_q <= sense_d;
			ctrl_q <= ctrl_d;
			edgeFlag_q <= edgeFlag_d;
			armed_q <= armed_d;
			reqPrev_q <= reqPrev_d;
		end
	end

	// Encoded level filter. In standby the peripheral clock is gone, so
	// sampling then advances only on the real-time clock edge.
	logic [`BUS_W-1:0] sampA_q, sampA_d;
	logic [`BUS_W-1:0] sampB_q, sampB_d;
	logic [`BUS_W-1:0] stableA_q, stableA_d;
	logic [`BUS_W-1:0] stableB_q, stableB_d;
	logic sampleTick;
	logic busBOn;
	ext_int_pkg::level_t levelA;
	ext_int_pkg::level_t levelB;
	ext_int_pkg::level_t encLevel;

	assign sampleTick = standbyIndicator ? (rtcRunning & rtcS &
		~rtcPrev_q) : 1'b1;
	assign busBOn = ctrl_q[`CTRL_LEVEL_MODE] &
		ctrl_q[`CTRL_SECOND_BUS];

	always_comb begin
		sampA_d = sampA_q;
		sampB_d = sampB_q;
		stableA_d = stableA_q;
		stableB_d = stableB_q;
		rtcPrev_d = rtcS;
		if (sampleTick) begin
			sampA_d = busAS;
			sampB_d = busBS;
			// Accept only a value seen on two samples in a row.
			if (busAS == sampA_q) begin
				stableA_d = busAS;
			end
			if (busBS == sampB_q) begin
				stableB_d = busBS;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			sampA_q <= `BUS_IDLE;
			sampB_q <= `BUS_IDLE;
			stableA_q <= `BUS_IDLE;
			stableB_q <= `BUS_IDLE;
			rtcPrev_q <= 1'b0;
		end else begin
			sampA_q <= sampA_d;
			sampB_q <= sampB_d;
			stableA_q <= stableA_d;
			stableB_q <= stableB_d;
			rtcPrev_q <= rtcPrev_d;
		end
	end

	// The source is trusted to hold or raise the level; a lowered one
	// simply shows the new lower level, nothing more.
	assign levelA = `LEVEL_MAX - stableA_q;
	assign levelB = busBOn ? (`LEVEL_MAX - stableB_q) :
		4'h0;
	assign encLevel = (levelB > levelA) ? levelB : levelA;

	// Priority selection over all sources.
	ext_int_pkg::level_t srcLevel [0:8];
	logic [8:0] srcOn;
	logic [8:0] srcWake;
	logic [`PRIO_W*2-1:0] reqPrio;
	logic portLoOn;
	logic portHiOn;
	logic [3:0] portLoPrio;
	logic [3:0] portHiPrio;

	assign reqPrio = {prioD_q, prioC_q};
	assign portLoPrio = prioD_q[`PORT_LO_PRIO_LSB +: 4];
	assign portHiPrio = prioD_q[`PORT_HI_PRIO_LSB +: 4];
	assign portLoOn = |portS[7:0];
	assign portHiOn = |portS[15:8];

	generate
		for (i = 0; i < `REQ_PINS; i++) begin : g_src
			assign srcLevel[i] = reqPrio[i*4 +: 4];
			assign srcOn[i] = reqActive[i];
			assign srcWake[i] = (i < `WAKE_REQ_PINS);
		end
	endgenerate
	assign srcLevel[6] = portLoPrio;
	assign srcOn[6] = portLoOn;
	// Only port pins 0 and 1 of the low group may wake the chip.
	assign srcWake[6] = 1'b0;
	assign srcLevel[7] = portHiPrio;
	assign srcOn[7] = portHiOn;
	assign srcWake[7] = 1'b0;
	assign srcLevel[8] = encLevel;
	assign srcOn[8] = 1'b1;
	assign srcWake[8] = 1'b1;

	logic bestOn;
	ext_int_pkg::level_t bestLevel;
	ext_int_pkg::source_t bestSrc;
	logic wakeHit;
	logic valid_q, valid_d;
	ext_int_pkg::level_t level_q, level_d;
	ext_int_pkg::source_t src_q, src_d;
	logic wake_q, wake_d;

	// Lower index wins a tie, giving a fixed default order.
	always_comb begin
		bestOn = 1'b0;
		bestLevel = 4'h0;
		bestSrc = ext_int_pkg::SRC_NONE;
		wakeHit = 1'b0;
		for (int k = 0; k < 9; k++) begin
			// Priority 0 never takes part.
			if (srcOn[k] && (srcLevel[k] != 4'h0) &&
				(srcLevel[k] > bestLevel)) begin
				bestOn = 1'b1;
				bestLevel = srcLevel[k];
				bestSrc = ext_int_pkg::source_t'(4'(k));
			end
			if (srcOn[k] && srcWake[k] &&
				(srcLevel[k] > cpuMaskLevel)) begin
				wakeHit = 1'b1;
			end
		end
		if (portS[1:0] != 2'h0 && portLoPrio > cpuMaskLevel) begin
			wakeHit = 1'b1;
		end
	end

	// The block only reports a level; the mask bits are the processor's
	// and stay untouched when it takes the request.
	always_comb begin
		valid_d = bestOn && (bestLevel > cpuMaskLevel);
		level_d = bestOn ? bestLevel : 4'h0;
		src_d = bestSrc;
		wake_d = standbyIndicator & rtcRunning &
			wakeHit;
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			valid_q <= 1'b0;
			level_q <= 4'h0;
			src_q <= ext_int_pkg::SRC_NONE;
			wake_q <= 1'b0;
		end else begin
			valid_q <= valid_d;
			level_q <= level_d;
			src_q <= src_d;
			wake_q <= wake_d;
		end
	end

	assign irqValid = valid_q;
	assign irqLevel = level_q;
	assign irqSource = src_q;
	assign wakeup = wake_q;
	assign priorityRegC = prioC_q;
	assign priorityRegD = prioD_q;
	assign senseControlReg = sense_q;
	assign ctrlReg = ctrl_q;
	// Level-sensed pins show their live state; bits 7:6 read as zero.
	assign reqFlagReg = {2'h0, (edgeMode & edgeFlag_q) |
		(~edgeMode & levelActive)};
endmodule
`default_nettype wire

// ==== dv/ext_int_checker.sv ====
// Purpose: Port assertions of the external interrupt detect block.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound into every instance of the block.
`timescale 1ns/100ps
`default_nettype none
module ext_int_checker (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Writes
	input wire logic prioCWe,
	input wire logic [15:0] prioCWdata,
	input wire logic prioDWe,
	input wire logic [15:0] prioDWdata,
	input wire logic senseWe,
	input wire logic [11:0] senseWdata,
	input wire logic ctrlWe,
	input wire logic [1:0] ctrlWdata,
	input wire logic flagWe,
	input wire logic [7:0] flagWdata,
	// Processor state
	input wire logic [3:0] cpuMaskLevel,
	input wire logic standbyIndicator,
	input wire logic rtcRunning,
	// Outputs
	input wire logic [15:0] priorityRegC,
	input wire logic [15:0] priorityRegD,
	input wire logic [11:0] senseControlReg,
	input wire logic [1:0] ctrlReg,
	input wire logic [7:0] reqFlagReg,
	input wire logic irqValid,
	input wire logic [3:0] irqLevel,
	input wire logic [3:0] irqSource,
	input wire logic wakeup
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	chk_reset_clears: assert property (
		disable iff (1'h0) reset |=> !irqValid && !wakeup
		&& irqSource == 4'hf && priorityRegC == 16'h0
		&& priorityRegD == 16'h0 && ctrlReg == 2'h0)
		else $error("outputs not cleared by reset");
	chk_prio_c: assert property (
		prioCWe |=> priorityRegC == $past(prioCWdata))
		else $error("priority c write lost");
	chk_prio_d: assert property (
		prioDWe |=> priorityRegD == $past(prioDWdata))
		else $error("priority d write lost");
	chk_sense_write: assert property (
		senseWe |=> senseControlReg == $past(senseWdata))
		else $error("sense write lost");
	chk_ctrl_write: assert property (
		ctrlWe |=> ctrlReg == $past(ctrlWdata))
		else $error("control write lost");
	chk_fwd_mask: assert property (
		irqValid |-> irqLevel > $past(cpuMaskLevel))
		else $error("request forwarded at or below mask");
	chk_fwd_nonzero: assert property (
		irqValid |-> irqLevel != 4'h0 && irqSource != 4'hf)
		else $error("request forwarded with no level");
	chk_flag_clear: assert property (
		senseControlReg[0] && $stable(senseControlReg)
		&& $fell(reqFlagReg[0]) |-> $past(flagWe) && !$past(flagWdata[0]))
		else $error("edge flag cleared without a write");
	chk_wake_standby: assert property (
		wakeup |-> $past(standbyIndicator) && $past(rtcRunning))
		else $error("wakeup outside standby with clock");
endmodule
bind external_interrupt_input_detect ext_int_checker u_chk (.*);
`default_nettype wire

// ==== dv/ext_pin_source.sv ====
// Purpose: External devices that drive the request pins.
// Assumes: Called from the bench just after a rising edge.
// Notes: Edge pins idle low and pulse high.
`timescale 1ns/100ps
`default_nettype none
module ext_pin_source (
	// Clock
	input wire logic mclk,
	// Pins
	output var logic [5:0] reqPins,
	output var logic [3:0] encodedLevelBusA,
	output var logic [3:0] encodedLevelBusB,
	output var logic [15:0] portIntPins
);
	initial begin
		reqPins = 6'h0;
		encodedLevelBusA = 4'hf;
		encodedLevelBusB = 4'hf;
		portIntPins = 16'h0;
	end
	// Three cycles, so the detector never sees a too-short pulse.
	task pulse(input int i);
		reqPins[i] = 1'h1;
		repeat (3) @(posedge mclk);
		#10 reqPins[i] = 1'h0;
	endtask
	// The bench drops a level only after it has checked the expected request.
	task levels(input logic [3:0] a, input logic [3:0] b);
		encodedLevelBusA = a;
		encodedLevelBusB = b;
	endtask
	task glitch;
		encodedLevelBusA = 4'h0;
		@(posedge mclk);
		#10 encodedLevelBusA = 4'hf;
	endtask
	task port(input logic [15:0] p);
		portIntPins = p;
	endtask
	task pin(input int i, input logic v);
		reqPins[i] = v;
	endtask
endmodule
`default_nettype wire

// ==== dv/external_interrupt_input_detect_bench.sv ====
// Purpose: Self-checking bench of the external interrupt detect block.
// Assumes: Request, bus and port pins come from the pin source model; rtcClk comes from the bench.
// Notes: Encoded cases come from a table, except the glitch and standby ones; the rest by hand.
`timescale 1ns/100ps
`default_nettype none
module external_interrupt_input_detect_bench;
	typedef struct {logic [3:0] a, b; logic [1:0] c;
		logic [3:0] m; logic v; logic [3:0] l;} row_t;
	row_t rows [9] = '{'{4'he, 4'hf, 2'h0, 4'h0, 1'h1, 4'h1},
		'{4'he, 4'h3, 2'h1, 4'h0, 1'h1, 4'h1},
		'{4'he, 4'h3, 2'h2, 4'h0, 1'h1, 4'h1},
		'{4'he, 4'h3, 2'h3, 4'h0, 1'h1, 4'hc},
		'{4'h3, 4'he, 2'h3, 4'h0, 1'h1, 4'hc},
		'{4'h5, 4'hf, 2'h0, 4'ha, 1'h0, 4'h0},
		'{4'h5, 4'hf, 2'h0, 4'h9, 1'h1, 4'ha},
		'{4'h0, 4'hf, 2'h0, 4'h0, 1'h1, 4'hf},
		'{4'hf, 4'hf, 2'h3, 4'h0, 1'h0, 4'h0}};
	logic mclk = 1'h0, reset = 1'h1, rtcClk = 1'h0;
	logic prioCWe = 1'h0, prioDWe = 1'h0, senseWe = 1'h0, ctrlWe = 1'h0;
	logic flagRd = 1'h0, flagWe = 1'h0, standbyIndicator = 1'h0;
	logic sleepPending = 1'h0, freqChangeCount = 1'h0, rtcRunning = 1'h0;
	logic [15:0] prioCWdata = 16'h0, prioDWdata = 16'h0;
	logic [11:0] senseWdata = 12'h0;
	logic [1:0] ctrlWdata = 2'h0;
	logic [7:0] flagWdata = 8'h0;
	logic [3:0] cpuMaskLevel = 4'h0;
	logic [3:0] encodedLevelBusA, encodedLevelBusB, irqLevel, irqSource;
	logic [5:0] reqPins;
	logic [15:0] portIntPins, priorityRegC, priorityRegD;
	logic [11:0] senseControlReg;
	logic [1:0] ctrlReg;
	logic [7:0] reqFlagReg;
	logic irqValid, wakeup;
	int mismatches = 0, checks = 0;
	always #50 mclk = ~mclk;
	always #15259 rtcClk = ~rtcClk;
	ext_pin_source u_src (.*);
	external_interrupt_input_detect u_dut (.*);
	task tick(input int n);
		repeat (n) @(posedge mclk);
		#10;
	endtask
	task check(input string what, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask
	task irq(input logic v, input logic [3:0] l, input logic [3:0] s);
		check("irqValid", 16'(v), 16'(irqValid));
		if (v) begin
			check("irqLevel", 16'(l), 16'(irqLevel));
			check("irqSource", 16'(s), 16'(irqSource));
		end
	endtask
	task regs(input logic [15:0] c, input logic [15:0] d,
		input logic [11:0] s, input logic [1:0] t);
		{prioCWe, prioDWe, senseWe, ctrlWe} = 4'hf;
		prioCWdata = c;
		prioDWdata = d;
		senseWdata = s;
		ctrlWdata = t;
		tick(1);
		{prioCWe, prioDWe, senseWe, ctrlWe} = 4'h0;
		tick(1);
	endtask
	task flagOp(input logic rd, input logic we, input logic [7:0] d);
		flagRd = rd;
		flagWe = we;
		flagWdata = d;
		tick(1);
		{flagRd, flagWe} = 2'h0;
		tick(1);
	endtask
	task clr;
		flagOp(1'h1, 1'h0, 8'h00);
		flagOp(1'h0, 1'h1, 8'h00);
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		#1000000;
		mismatches++;
		final_report;
	end
	initial begin
		tick(5);
		reset = 1'h0;
		tick(4);
		irq(1'h0, 4'h0, 4'h0);
		check("prioC", 16'h0, priorityRegC);
		check("ctrl", 16'h0, 16'(ctrlReg));
		check("levelFlags", 16'h3f, 16'(reqFlagReg));
		foreach (rows[i]) begin
			ctrlWe = 1'h1;
			ctrlWdata = rows[i].c;
			cpuMaskLevel = rows[i].m;
			u_src.levels(rows[i].a, rows[i].b);
			tick(1);
			ctrlWe = 1'h0;
			tick(8);
			irq(rows[i].v, rows[i].l, 4'h8);
			u_src.levels(4'hf, 4'hf);
			tick(8);
		end
		u_src.glitch;
		repeat (8) begin
			tick(1);
			irq(1'h0, 4'h0, 4'h0);
		end
		cpuMaskLevel = 4'hf;
		regs(16'h4321, 16'h9865, 12'hfff, 2'h0);
		clr;
		cpuMaskLevel = 4'h0;
		check("prioD", 16'h9865, priorityRegD);
		check("sense", 16'hfff, 16'(senseControlReg));
		u_src.pulse(3);
		tick(3);
		check("flags", 16'h08, 16'(reqFlagReg));
		irq(1'h1, 4'h4, 4'h3);
		flagOp(1'h0, 1'h1, 8'h00);
		check("flags", 16'h08, 16'(reqFlagReg));
		clr;
		check("flags", 16'h00, 16'(reqFlagReg));
		regs(16'h4320, 16'h9865, 12'hfff, 2'h0);
		u_src.pulse(0);
		tick(3);
		irq(1'h0, 4'h0, 4'h0);
		clr;
		freqChangeCount = 1'h1;
		u_src.pulse(2);
		tick(3);
		check("flags", 16'h00, 16'(reqFlagReg));
		{freqChangeCount, sleepPending, standbyIndicator} = 3'h3;
		rtcRunning = 1'h1;
		u_src.pulse(2);
		tick(3);
		check("flags", 16'h04, 16'(reqFlagReg));
		check("wakeup", 16'h1, 16'(wakeup));
		clr;
		u_src.pulse(5);
		tick(3);
		check("wakeup", 16'h0, 16'(wakeup));
		clr;
		u_src.port(16'h0002);
		tick(4);
		check("wakeup", 16'h1, 16'(wakeup));
		irq(1'h1, 4'h9, 4'h6);
		rtcRunning = 1'h0;
		tick(2);
		check("wakeup", 16'h0, 16'(wakeup));
		u_src.port(16'h0100);
		tick(4);
		irq(1'h1, 4'h8, 4'h7);
		// In standby the filter steps on the slow clock only, so a new
		// level needs two slow edges before it counts.
		u_src.port(16'h0000);
		rtcRunning = 1'h1;
		u_src.levels(4'h2, 4'hf);
		tick(10);
		irq(1'h0, 4'h0, 4'h0);
		tick(700);
		check("wakeup", 16'h1, 16'(wakeup));
		irq(1'h1, 4'hd, 4'h8);
		u_src.levels(4'hf, 4'hf);
		{sleepPending, standbyIndicator} = 2'h2;
		regs(16'h5555, 16'h0077, 12'hf81, 2'h0);
		u_src.pulse(0);
		tick(4);
		check("flags", 16'h00, 16'(reqFlagReg));
		sleepPending = 1'h0;
		u_src.pulse(0);
		tick(4);
		check("flags", 16'h01, 16'(reqFlagReg));
		irq(1'h1, 4'h5, 4'h0);
		flagOp(1'h1, 1'h0, 8'h00);
		flagOp(1'h0, 1'h1, 8'h01);
		check("flags", 16'h01, 16'(reqFlagReg));
		clr;
		u_src.pin(4, 1'h1);
		tick(4);
		check("flags", 16'h10, 16'(reqFlagReg));
		irq(1'h1, 4'h7, 4'h4);
		u_src.pin(4, 1'h0);
		reset = 1'h1;
		tick(5);
		reset = 1'h0;
		tick(4);
		irq(1'h0, 4'h0, 4'h0);
		check("prioD", 16'h0, priorityRegD);
		check("sense", 16'h0, 16'(senseControlReg));
		check("levelFlags", 16'h3f, 16'(reqFlagReg));
		final_report;
	end
endmodule
`default_nettype wire
